// *** shared/kcn_pkg.sv ***
`default_nettype none
package kcn_pkg;

  // ----------------------------------------
  // Clock and key filter timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;     // System clock rate
  localparam int DEBOUNCE_MS = 10;         // Settle time of a key contact, ms
  localparam int DEB_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;  // Stable cycles before accept

  // ----------------------------------------
  // Widths and key indices
  // ----------------------------------------
  localparam int GROUP_W = 4;              // Group selector width
  localparam int CODE_W = 7;               // Code number width (0..99)
  localparam int MAP_AW = GROUP_W + CODE_W;  // Code map address width
  localparam int NUM_KEYS = 4;             // Up, down, mode, confirm
  localparam int VAL_DIGITS = 4;           // BCD digits of a parameter value
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_MODE = 2;
  localparam int KEY_CONFIRM = 3;

  // ----------------------------------------
  // Groups and fixed codes
  // ----------------------------------------
  localparam logic [3:0] GRP_OPERATION = 4'h0;   // Operation group
  localparam logic [3:0] GRP_ADVANCED = 4'h3;    // Advanced group
  localparam logic [6:0] FREQ_REF_CODE = 7'h00;        // Frequency reference (initial)
  localparam logic [6:0] ACCEL_TIME_CODE = 7'h01;      // Acceleration time
  localparam logic [6:0] DECEL_TIME_CODE = 7'h02;      // Deceleration time
  localparam logic [6:0] GROUP_REVEAL_CODE = 7'h03;    // Last code of Operation group
  localparam logic [6:0] GRP_LAST_CODE = 7'h63;        // Last code of other groups (99)
  localparam logic [6:0] FREQ_LIMIT_ENABLE_CODE = 7'h18;  // 24
  localparam logic [6:0] FREQ_UPPER_LIMIT_CODE = 7'h19;   // 25
  localparam logic [6:0] FREQ_LOWER_LIMIT_CODE = 7'h1A;   // 26

  // ----------------------------------------
  // Code entry defaults (BCD) and reset values
  // ----------------------------------------
  localparam logic [3:0] ADV_ENTRY_TENS = 4'h2;    // Advanced default 24
  localparam logic [3:0] ADV_ENTRY_ONES = 4'h4;
  localparam logic [3:0] OTHER_ENTRY_TENS = 4'h0;  // Other groups default 01
  localparam logic [3:0] OTHER_ENTRY_ONES = 4'h1;
  localparam logic [1:0] CURSOR_RIGHT = 2'h0;      // Rightmost digit
  localparam logic [1:0] CURSOR_LEFT = 2'h3;       // Leftmost value digit
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [6:0] CODE_RESET = 7'h00;

  // ----------------------------------------
  // Navigation state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_BROWSE = 3'h0,      // Code shown, waiting for a key
    ST_SEEK = 3'h1,        // Candidate code presented to the map
    ST_SEEK_CHK = 3'h2,    // Map answer for the candidate checked
    ST_ENTRY = 3'h3,       // Code number being typed
    ST_VALUE_EDIT = 3'h4,  // Value digits being edited
    ST_VALUE_HOLD = 3'h5   // Whole value flashing, awaiting confirm
  } kcn_state_t;

endpackage
`default_nettype wire

// *** hw/kcn_key_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_key_filter #(
  parameter int DEB_CYCLES = kcn_pkg::DEB_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic key_raw,      // Key contact level, high while pressed
  output logic key_press         // One-cycle pulse per accepted press
);

  localparam int CNT_W = $clog2(DEB_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

  logic stable_r;                // Accepted key level
  logic [CNT_W-1:0] cnt_r;       // Cycles the raw level has differed
  logic differ;                  // Raw level disagrees with accepted one
  logic settle;                  // Disagreement lasted long enough

  assign differ = key_raw != stable_r;
  assign settle = differ && (cnt_r == CNT_LAST);

  // ----------------------------------------
  // Settle counter
  // ----------------------------------------
  // Any bounce back to the accepted level restarts the wait
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (!differ || settle) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Accepted level and press pulse, once per press
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_r <= 1'b0;
      key_press <= 1'b0;
    end else begin
      if (settle) begin
        stable_r <= key_raw;
      end
      key_press <= settle && key_raw;
    end
  end

endmodule
`default_nettype wire

// *** hw/kcn_code_map.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_code_map #(
  parameter int AW = kcn_pkg::MAP_AW
) (
  input wire logic clk,
  input wire logic wr_en,        // Load one entry
  input wire logic [AW-1:0] wr_addr,
  input wire logic wr_data,      // 1 = code has an assigned function
  input wire logic [AW-1:0] rd_addr,
  output logic rd_data           // Registered, one cycle after rd_addr
);

  // One bit per group and code; no reset, the system loads it
  logic mem_r [0:(1<<AW)-1];

  // ----------------------------------------
  // Write and registered read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end

endmodule
`default_nettype wire

// *** hw/kcn_code_nav.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_code_nav #(
  parameter int DEB_CYCLES = kcn_pkg::DEB_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic key_up_raw,          // Up key level
  input wire logic key_down_raw,        // Down key level
  input wire logic key_mode_raw,        // Mode key level
  input wire logic key_confirm_raw,     // Confirm key level
  input wire logic [3:0] group_sel,     // Current group, steered elsewhere
  input wire logic freq_limit_en,       // Value held by the limit enable code
  input wire logic [15:0] param_value,  // BCD value of the shown code
  input wire logic map_wr_en,           // Code map load strobe
  input wire logic [10:0] map_wr_addr,  // {group, code}
  input wire logic map_wr_data,         // 1 = code assigned
  output logic [6:0] shown_code,        // Code number on display
  output logic entry_active,            // Code number entry open
  output logic [7:0] entry_digits,      // Typed code, {tens, ones} BCD
  output logic value_edit_active,       // Digit editing of a value
  output logic [15:0] value_digits,     // Pending value, BCD
  output logic [1:0] cursor_pos,        // Flashing digit, 0 = rightmost
  output logic flash_all,               // Whole value flashing
  output logic seek_busy,               // Searching for next code
  output logic commit_stb,              // Pulse: store value to code
  output logic [6:0] commit_code,       // Code being stored
  output logic [15:0] commit_value,     // Value being stored
  output logic cancel_stb               // Pulse: pending change dropped
);

  // ----------------------------------------
  // Key filtering
  // ----------------------------------------
  logic [kcn_pkg::NUM_KEYS-1:0] key_raw;    // Keys gathered for the loop
  logic [kcn_pkg::NUM_KEYS-1:0] key_press;  // Filtered press pulses

  assign key_raw = {key_confirm_raw, key_mode_raw, key_down_raw, key_up_raw};

  // One filter per key; each gives one pulse per press
  genvar k;
  generate
    for (k = 0; k < kcn_pkg::NUM_KEYS; k++) begin : g_key
      kcn_key_filter #(
        .DEB_CYCLES(DEB_CYCLES)
      ) u_filter (
        .clk(clk),
        .reset_n(reset_n),
        .key_raw(key_raw[k]),
        .key_press(key_press[k])
      );
    end
  endgenerate

  // Presses in the same cycle resolve by priority: confirm, mode, up, down
  logic ev_confirm;
  logic ev_mode;
  logic ev_up;
  logic ev_down;
  logic ev_any;
  assign ev_confirm = key_press[kcn_pkg::KEY_CONFIRM];
  assign ev_mode = key_press[kcn_pkg::KEY_MODE] && !ev_confirm;
  assign ev_up = key_press[kcn_pkg::KEY_UP] && !ev_confirm && !ev_mode;
  assign ev_down = key_press[kcn_pkg::KEY_DOWN] && !ev_confirm && !ev_mode && !ev_up;
  assign ev_any = |key_press;

  // ----------------------------------------
  // State
  // ----------------------------------------
  kcn_pkg::kcn_state_t state_r;   // Navigation state
  kcn_pkg::kcn_state_t state_nxt;
  logic [6:0] code_r;             // Shown code
  logic [6:0] code_nxt;
  logic [6:0] cand_r;             // Candidate code under test
  logic [6:0] cand_nxt;
  logic dir_up_r;                 // Search direction
  logic dir_up_nxt;
  logic jump_r;                   // Candidate came from code entry
  logic jump_nxt;
  logic [3:0] tens_r;             // Entry tens digit
  logic [3:0] tens_nxt;
  logic [3:0] ones_r;             // Entry ones digit
  logic [3:0] ones_nxt;
  logic [1:0] cursor_r;           // Flashing digit index
  logic [1:0] cursor_nxt;
  logic [15:0] value_r;           // Pending value
  logic [15:0] value_nxt;
  logic [3:0] group_r;            // Group seen last cycle
  logic commit_nxt;
  logic cancel_nxt;

  // ----------------------------------------
  // Group facts and code stepping
  // ----------------------------------------
  logic op_group;                 // Operation group has a fixed short list
  logic adv_group;
  logic group_moved;              // Group changed: restart at its code 0
  logic [6:0] last_code;          // Last code of this group
  logic [6:0] step_up;            // Next candidate going up
  logic [6:0] step_down;          // Next candidate going down
  logic [6:0] step_from;          // Code the step starts at
  logic [6:0] entry_code;         // Typed code in binary

  assign op_group = group_sel == kcn_pkg::GRP_OPERATION;
  assign adv_group = group_sel == kcn_pkg::GRP_ADVANCED;
  assign group_moved = group_sel != group_r;
  // Operation order is reference, accel, decel, group reveal
  assign last_code = op_group ? kcn_pkg::GROUP_REVEAL_CODE : kcn_pkg::GRP_LAST_CODE;
  assign step_from = (state_r == kcn_pkg::ST_SEEK_CHK) ? cand_r : code_r;
  assign step_up = (step_from >= last_code) ? kcn_pkg::CODE_RESET
                                            : step_from + 7'h01;
  assign step_down = (step_from == kcn_pkg::CODE_RESET) ? last_code
                                                        : step_from - 7'h01;
  assign entry_code = 7'(tens_r * 7'd10) + 7'(ones_r);

  // ----------------------------------------
  // Accessibility of the candidate
  // ----------------------------------------
  logic map_hit;                  // Candidate has an assigned function
  logic limit_hidden;             // Candidate is a limit code now hidden
  logic cand_ok;

  kcn_code_map #(
    .AW(kcn_pkg::MAP_AW)
  ) u_map (
    .clk(clk),
    .wr_en(map_wr_en),
    .wr_addr(map_wr_addr),
    .wr_data(map_wr_data),
    .rd_addr({group_sel, cand_r}),
    .rd_data(map_hit)
  );

  // Limit codes depend on the enable value as well as on the map
  assign limit_hidden = adv_group && !freq_limit_en &&
                        (cand_r == kcn_pkg::FREQ_UPPER_LIMIT_CODE ||
                         cand_r == kcn_pkg::FREQ_LOWER_LIMIT_CODE);
  // Code 0 always counts, so a search always ends within one lap
  assign cand_ok = op_group || cand_r == kcn_pkg::CODE_RESET ||
                   (map_hit && !limit_hidden);

  // ----------------------------------------
  // Digit stepping
  // ----------------------------------------
  function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
    logic [3:0] r;
    r = 4'h0;
    if (up) begin
      r = (d >= kcn_pkg::BCD_MAX) ? 4'h0 : d + 4'h1;
    end else begin
      r = (d == 4'h0 || d > kcn_pkg::BCD_MAX) ? kcn_pkg::BCD_MAX : d - 4'h1;
    end
    return r;
  endfunction

  logic [15:0] value_step;        // Value with cursor digit stepped
  genvar g;
  generate
    for (g = 0; g < kcn_pkg::VAL_DIGITS; g++) begin : g_digit
      assign value_step[g*4 +: 4] = (cursor_r == 2'(g)) ? bcd_step(value_r[g*4 +: 4], ev_up)
                                                      : value_r[g*4 +: 4];
    end
  endgenerate

  logic [3:0] tens_step;
  logic [3:0] ones_step;
  assign tens_step = bcd_step(tens_r, ev_up);
  assign ones_step = bcd_step(ones_r, ev_up);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Keys arriving during a search are dropped; a search takes two cycles per candidate code
  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    cand_nxt = cand_r;
    dir_up_nxt = dir_up_r;
    jump_nxt = jump_r;
    tens_nxt = tens_r;
    ones_nxt = ones_r;
    cursor_nxt = cursor_r;
    value_nxt = value_r;
    commit_nxt = 1'b0;
    cancel_nxt = 1'b0;
    unique case (state_r)
      kcn_pkg::ST_BROWSE: begin
        if (ev_confirm && !op_group && code_r == kcn_pkg::CODE_RESET) begin
          // Entry starts from the group's usual code, right digit flashing
          state_nxt = kcn_pkg::ST_ENTRY;
          tens_nxt = adv_group ? kcn_pkg::ADV_ENTRY_TENS : kcn_pkg::OTHER_ENTRY_TENS;
          ones_nxt = adv_group ? kcn_pkg::ADV_ENTRY_ONES : kcn_pkg::OTHER_ENTRY_ONES;
          cursor_nxt = kcn_pkg::CURSOR_RIGHT;
        end else if (ev_confirm) begin
          // Edit a copy; the stored value is untouched until commit
          state_nxt = kcn_pkg::ST_VALUE_EDIT;
          value_nxt = param_value;
          cursor_nxt = kcn_pkg::CURSOR_RIGHT;
        end else if (ev_up || ev_down) begin
          state_nxt = kcn_pkg::ST_SEEK;
          cand_nxt = ev_up ? step_up : step_down;
          dir_up_nxt = ev_up;
          jump_nxt = 1'b0;
        end
      end
      kcn_pkg::ST_SEEK: begin
        // Map answer for cand_r arrives next cycle
        state_nxt = kcn_pkg::ST_SEEK_CHK;
      end
      kcn_pkg::ST_SEEK_CHK: begin
        if (cand_ok) begin
          state_nxt = kcn_pkg::ST_BROWSE;
          code_nxt = cand_r;
        end else if (jump_r) begin
          // A typed code that cannot be shown leaves the display as it was
          state_nxt = kcn_pkg::ST_BROWSE;
        end else begin
          state_nxt = kcn_pkg::ST_SEEK;
          cand_nxt = dir_up_r ? step_up : step_down;
        end
      end
      kcn_pkg::ST_ENTRY: begin
        if (ev_confirm) begin
          state_nxt = kcn_pkg::ST_SEEK;
          cand_nxt = (entry_code > last_code) ? last_code : entry_code;
          jump_nxt = 1'b1;
        end else if (ev_mode) begin
          cursor_nxt = {1'b0, ~cursor_r[0]};
        end else if ((ev_up || ev_down) && cursor_r[0]) begin
          tens_nxt = tens_step;
        end else if (ev_up || ev_down) begin
          ones_nxt = ones_step;
        end
      end
      kcn_pkg::ST_VALUE_EDIT: begin
        if (ev_confirm) begin
          state_nxt = kcn_pkg::ST_VALUE_HOLD;
        end else if (ev_mode) begin
          cursor_nxt = (cursor_r == kcn_pkg::CURSOR_LEFT) ? kcn_pkg::CURSOR_RIGHT
                                                          : cursor_r + 2'h1;
        end else if (ev_up || ev_down) begin
          value_nxt = value_step;
        end
      end
      kcn_pkg::ST_VALUE_HOLD: begin
        if (ev_confirm) begin
          state_nxt = kcn_pkg::ST_BROWSE;
          commit_nxt = 1'b1;
        end else if (ev_any) begin
          state_nxt = kcn_pkg::ST_BROWSE;
          cancel_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = kcn_pkg::ST_BROWSE;
      end
    endcase
    // A group change always lands on the new group's code 0
    if (group_moved) begin
      state_nxt = kcn_pkg::ST_BROWSE;
      code_nxt = kcn_pkg::CODE_RESET;
      commit_nxt = 1'b0;
      cancel_nxt = state_r == kcn_pkg::ST_VALUE_EDIT || state_r == kcn_pkg::ST_VALUE_HOLD;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Navigation state and shown code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= kcn_pkg::ST_BROWSE;
      code_r <= kcn_pkg::CODE_RESET;
      cand_r <= kcn_pkg::CODE_RESET;
      dir_up_r <= 1'b1;
      jump_r <= 1'b0;
      group_r <= kcn_pkg::GRP_OPERATION;
    end else begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      cand_r <= cand_nxt;
      dir_up_r <= dir_up_nxt;
      jump_r <= jump_nxt;
      group_r <= group_sel;
    end
  end

  // Edit digits and cursor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tens_r <= 4'h0;
      ones_r <= 4'h0;
      cursor_r <= kcn_pkg::CURSOR_RIGHT;
      value_r <= 16'h0000;
    end else begin
      tens_r <= tens_nxt;
      ones_r <= ones_nxt;
      cursor_r <= cursor_nxt;
      value_r <= value_nxt;
    end
  end

  // Store and cancel pulses with the data they carry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      commit_stb <= 1'b0;
      cancel_stb <= 1'b0;
      commit_code <= kcn_pkg::CODE_RESET;
      commit_value <= 16'h0000;
    end else begin
      commit_stb <= commit_nxt;
      cancel_stb <= cancel_nxt;
      if (commit_nxt) begin
        commit_code <= code_r;
        commit_value <= value_r;
      end
    end
  end

  // ----------------------------------------
  // Display outputs
  // ----------------------------------------
  assign shown_code = code_r;
  assign entry_active = state_r == kcn_pkg::ST_ENTRY;
  assign entry_digits = {tens_r, ones_r};
  assign value_edit_active = state_r == kcn_pkg::ST_VALUE_EDIT;
  assign value_digits = value_r;
  assign cursor_pos = cursor_r;
  assign flash_all = state_r == kcn_pkg::ST_VALUE_HOLD;
  assign seek_busy = state_r == kcn_pkg::ST_SEEK || state_r == kcn_pkg::ST_SEEK_CHK;

endmodule
`default_nettype wire

// *** tb/kcn_code_nav_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_code_nav_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] group_sel,
  input wire logic freq_limit_en,
  input wire logic [6:0] shown_code,
  input wire logic entry_active,
  input wire logic [7:0] entry_digits,
  input wire logic value_edit_active,
  input wire logic [15:0] value_digits,
  input wire logic [1:0] cursor_pos,
  input wire logic flash_all,
  input wire logic seek_busy,
  input wire logic commit_stb,
  input wire logic [15:0] commit_value,
  input wire logic cancel_stb
);
  // ----
  // One clock domain, so one default clocking and one disable
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Operation group held long enough for a group change to settle
  sequence s_op_steady;
    (group_sel == kcn_pkg::GRP_OPERATION) [*3];
  endsequence
  // Limit codes hidden in the advanced group for two cycles
  sequence s_hidden_limits;
    (group_sel == kcn_pkg::GRP_ADVANCED && !freq_limit_en) [*2];
  endsequence
  property p_op_order;
    s_op_steady |-> shown_code <= kcn_pkg::GROUP_REVEAL_CODE;
  endproperty
  a_op_order: assert property (p_op_order) else $error("operation code out of range");
  property p_op_no_entry;
    s_op_steady |-> !entry_active;
  endproperty
  a_op_no_entry: assert property (p_op_no_entry) else $error("entry in operation");
  property p_entry_preload;
    $rose(entry_active) && group_sel == kcn_pkg::GRP_ADVANCED |->
      entry_digits == {kcn_pkg::ADV_ENTRY_TENS, kcn_pkg::ADV_ENTRY_ONES} &&
      cursor_pos == kcn_pkg::CURSOR_RIGHT;
  endproperty
  a_entry_preload: assert property (p_entry_preload) else $error("bad entry preload");
  property p_entry_cursor;
    entry_active |-> cursor_pos <= 2'h1;
  endproperty
  a_entry_cursor: assert property (p_entry_cursor) else $error("entry cursor off");
  property p_limit_hidden;
    s_hidden_limits |-> shown_code != kcn_pkg::FREQ_UPPER_LIMIT_CODE &&
      shown_code != kcn_pkg::FREQ_LOWER_LIMIT_CODE;
  endproperty
  a_limit_hidden: assert property (p_limit_hidden) else $error("hidden limit shown");
  property p_seek_bound;
    $rose(seek_busy) |-> ##[1:400] !seek_busy;
  endproperty
  a_seek_bound: assert property (p_seek_bound) else $error("search never ends");
  property p_edit_start;
    $rose(value_edit_active) |-> cursor_pos == kcn_pkg::CURSOR_RIGHT && !flash_all;
  endproperty
  a_edit_start: assert property (p_edit_start) else $error("bad value edit start");
  property p_commit;
    commit_stb |-> $past(flash_all, 2) && commit_value == $past(value_digits, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("store without flashing value");
  property p_commit_pulse;
    commit_stb |=> !commit_stb;
  endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("store pulse too long");
  property p_cancel_pulse;
    cancel_stb |=> !cancel_stb && !commit_stb;
  endproperty
  a_cancel_pulse: assert property (p_cancel_pulse) else $error("drop pulse wrong");
endmodule
bind kcn_code_nav kcn_code_nav_sva u_sva (.clk(clk), .reset_n(reset_n), .group_sel(group_sel),
  .freq_limit_en(freq_limit_en), .shown_code(shown_code), .entry_active(entry_active),
  .entry_digits(entry_digits), .value_edit_active(value_edit_active),
  .value_digits(value_digits), .cursor_pos(cursor_pos), .flash_all(flash_all),
  .seek_busy(seek_busy), .commit_stb(commit_stb), .commit_value(commit_value),
  .cancel_stb(cancel_stb));
`default_nettype wire

// *** tb/kcn_keypad_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_keypad_model #(
  parameter int DEB = 4
) (
  input wire logic clk,
  output logic [3:0] key_raw
);
  // ----
  // Operator: one key at a time, with contact bounce
  // ----
  initial key_raw = 4'h0;
  // A single press; the glitch is shorter than the filter span so it must vanish
  task automatic press(input int k);
    @(posedge clk);
    key_raw[k] <= 1'b1;
    @(posedge clk);
    key_raw[k] <= 1'b0;
    repeat (2) @(posedge clk);
    key_raw[k] <= 1'b1;
    repeat (2 * DEB) @(posedge clk);
    key_raw[k] <= 1'b0;
    // Release lasts well past the filter span, so presses never merge
    repeat (3 * DEB) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/kcn_code_nav_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module kcn_code_nav_tb;
  localparam int DEB = 4; // Short filter span keeps the run brief
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] key_raw;
  logic [3:0] group_sel = 4'h0;
  logic freq_limit_en = 1'b0;
  logic [15:0] param_value = 16'h0509; // Ones digit 9 shows the wrap
  logic map_wr_en = 1'b0;
  logic [10:0] map_wr_addr = 11'h000;
  logic map_wr_data = 1'b0;
  logic [6:0] shown_code, commit_code;
  logic [7:0] entry_digits;
  logic [15:0] value_digits, commit_value;
  logic [1:0] cursor_pos;
  logic entry_active, value_edit_active, flash_all, seek_busy, commit_stb, cancel_stb;
  int n_errors = 0;
  int checked = 0;
  int n_commit = 0;
  int n_cancel = 0;
  always #4 clk = ~clk;
  kcn_keypad_model #(.DEB(DEB)) op (.clk(clk), .key_raw(key_raw));
  kcn_code_nav #(.DEB_CYCLES(DEB)) dut (.clk(clk), .reset_n(reset_n),
    .key_up_raw(key_raw[kcn_pkg::KEY_UP]), .key_down_raw(key_raw[kcn_pkg::KEY_DOWN]),
    .key_mode_raw(key_raw[kcn_pkg::KEY_MODE]),
    .key_confirm_raw(key_raw[kcn_pkg::KEY_CONFIRM]), .group_sel(group_sel),
    .freq_limit_en(freq_limit_en), .param_value(param_value), .map_wr_en(map_wr_en),
    .map_wr_addr(map_wr_addr), .map_wr_data(map_wr_data), .shown_code(shown_code),
    .entry_active(entry_active), .entry_digits(entry_digits),
    .value_edit_active(value_edit_active), .value_digits(value_digits),
    .cursor_pos(cursor_pos), .flash_all(flash_all), .seek_busy(seek_busy),
    .commit_stb(commit_stb), .commit_code(commit_code), .commit_value(commit_value),
    .cancel_stb(cancel_stb));
  // Strobes last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (commit_stb === 1'b1) n_commit <= n_commit + 1;
    if (cancel_stb === 1'b1) n_cancel <= n_cancel + 1;
  end
  // ----
  // Shared helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Press, then wait out any search; bounded so a stuck search cannot hang
  task automatic press(input int k);
    int i;
    op.press(k);
    i = 0;
    while (seek_busy !== 1'b0 && i < 400) begin
      @(posedge clk);
      i++;
    end
    if (i >= 400) n_errors++;
    #1;
  endtask
  task automatic set_group(input logic [3:0] g);
    @(posedge clk);
    group_sel <= g;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_oper();
    logic [6:0] seq [4];
    seq = '{kcn_pkg::ACCEL_TIME_CODE, kcn_pkg::DECEL_TIME_CODE,
      kcn_pkg::GROUP_REVEAL_CODE, kcn_pkg::FREQ_REF_CODE};
    for (int i = 0; i < 4; i++) begin
      press(kcn_pkg::KEY_UP);
      chk(16'(shown_code), 16'(seq[i]));
    end
    press(kcn_pkg::KEY_DOWN);
    chk(16'(shown_code), 16'(kcn_pkg::GROUP_REVEAL_CODE));
    press(kcn_pkg::KEY_UP);
    $display("test oper done");
  endtask
  // Confirm at the operation start code edits the value; a stray key drops it
  task automatic t_op_value();
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(entry_active), 16'h0000);
    chk(16'(value_edit_active), 16'h0001);
    chk(value_digits, param_value);
    press(kcn_pkg::KEY_UP);
    chk(value_digits, 16'h0500);
    press(kcn_pkg::KEY_MODE);
    chk(16'(cursor_pos), 16'h0001);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(flash_all), 16'h0001);
    press(kcn_pkg::KEY_DOWN);
    chk(16'(n_cancel), 16'h0001);
    chk(16'(n_commit), 16'h0000);
    chk(16'(value_edit_active | flash_all), 16'h0000);
    $display("test op value done");
  endtask
  task automatic t_adv_entry();
    set_group(kcn_pkg::GRP_ADVANCED);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(entry_active), 16'h0001);
    chk(16'(entry_digits), 16'h0024);
    press(kcn_pkg::KEY_MODE);
    chk(16'(cursor_pos), 16'h0001);
    press(kcn_pkg::KEY_DOWN);
    chk(16'(entry_digits), 16'h0014);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(shown_code), 16'd14);
    chk(16'(entry_active), 16'h0000);
    press(kcn_pkg::KEY_DOWN);
    chk(16'(shown_code), 16'd13);
    $display("test adv entry done");
  endtask
  // Wrap downward, then step across the hidden then visible limit codes
  task automatic t_skip();
    set_group(kcn_pkg::GRP_OPERATION);
    set_group(kcn_pkg::GRP_ADVANCED);
    press(kcn_pkg::KEY_DOWN);
    chk(16'(shown_code), 16'(kcn_pkg::GRP_LAST_CODE));
    set_group(kcn_pkg::GRP_OPERATION);
    set_group(kcn_pkg::GRP_ADVANCED);
    press(kcn_pkg::KEY_CONFIRM);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(shown_code), 16'(kcn_pkg::FREQ_LIMIT_ENABLE_CODE));
    press(kcn_pkg::KEY_UP);
    chk(16'(shown_code), 16'd27);
    @(posedge clk);
    freq_limit_en <= 1'b1;
    press(kcn_pkg::KEY_DOWN);
    chk(16'(shown_code), 16'(kcn_pkg::FREQ_LOWER_LIMIT_CODE));
    press(kcn_pkg::KEY_DOWN);
    chk(16'(shown_code), 16'(kcn_pkg::FREQ_UPPER_LIMIT_CODE));
    $display("test skip done");
  endtask
  task automatic t_adv_value();
    press(kcn_pkg::KEY_CONFIRM);
    chk(value_digits, param_value);
    press(kcn_pkg::KEY_UP);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(flash_all), 16'h0001);
    press(kcn_pkg::KEY_CONFIRM);
    chk(16'(n_commit), 16'h0001);
    chk(16'(commit_code), 16'(kcn_pkg::FREQ_UPPER_LIMIT_CODE));
    chk(commit_value, 16'h0500);
    chk(16'(value_edit_active), 16'h0000);
    press(kcn_pkg::KEY_CONFIRM);
    set_group(kcn_pkg::GRP_OPERATION);
    chk(16'(n_cancel), 16'h0002);
    $display("test adv value done");
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Every advanced code assigned; only the limit enable can hide codes
    for (int c = 0; c < 100; c++) begin
      @(posedge clk);
      map_wr_en <= 1'b1;
      map_wr_addr <= {kcn_pkg::GRP_ADVANCED, 7'(c)};
      map_wr_data <= 1'b1;
    end
    @(posedge clk);
    map_wr_en <= 1'b0;
    t_oper();
    t_op_value();
    t_adv_entry();
    t_skip();
    t_adv_value();
    report_and_stop();
  end
  // Twenty-seven presses of about twenty-four cycles each; far more is a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
